// File: src/crx_fifo.sv
// parameterised valid/ready fifo holding accepted frames and hit indices
`timescale 1ns/1ns
`include "crx_map.svh"
module crx_fifo #(
   parameter int W = 99,
   parameter int D = `CRX_FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(D);
   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0]   cnt;
   } crx_fifo_st_t;
   crx_fifo_st_t s_q, s_d;
   logic [W-1:0] mem [D];
   logic push, pop;

   // handshakes are combinational, full and empty from the count
   assign in_ready  = (s_q.cnt != (PW+1)'(D));
   assign out_valid = (s_q.cnt != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[s_q.rp];

   always_comb begin
      s_d = s_q;
      if (push) s_d.wp = s_q.wp + PW'(1);
      if (pop) s_d.rp = s_q.rp + PW'(1);
      s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
         if (push) mem[s_q.wp] <= in_data;
      end
   end
endmodule

// File: src/crx_map.svh
// constant map for the can receive fifo and identifier filter
`ifndef CRX_MAP_SVH
`define CRX_MAP_SVH
`define CRX_FIFO_DEPTH   4
`define CRX_FIFO_PTR_W   2
`define CRX_FIFO_CNT_W   3
`define CRX_FRAME_W      96
`define CRX_IDW_W        32
`define CRX_MODE_TWO     2'h0
`define CRX_MODE_FOUR    2'h1
`define CRX_MODE_EIGHT   2'h2
`define CRX_MODE_CLOSED  2'h3
`define CRX_HIT_NONE     3'h0
`endif

// File: src/crx_pkg.sv
// types for the can receive fifo and identifier filter
package crx_pkg;
   typedef enum logic [1:0] {
      CRX_IDLE = 2'b00,
      CRX_RECV = 2'b01,
      CRX_XMIT = 2'b10
   } crx_state_t;
endpackage

// File: src/crx_rx_filter.sv
// can receive path: background buffer, acceptance filter, fifo hand-off
`timescale 1ns/1ns
`include "crx_map.svh"
module crx_rx_filter
   import crx_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    ce,
   input  wire logic                    loopback_en,
   input  wire logic                    overrun_irq_en,
   input  wire logic [1:0]              acceptance_mode,
   input  wire logic [63:0]             acceptance_code_regs,
   input  wire logic [63:0]             acceptance_mask_regs,
   input  wire logic                    tx_active,
   input  wire logic                    arb_lost,
   input  wire logic                    frame_start,
   input  wire logic                    frame_done,
   input  wire logic                    frame_error,
   input  wire logic [`CRX_IDW_W-1:0]   frame_id_word,
   input  wire logic [63:0]             frame_payload,
   output logic                         ack_enable,
   output logic                         rx_buffer_full_flag,
   output logic [2:0]                   filter_hit_index,
   output logic [`CRX_IDW_W-1:0]        rx_id_word,
   output logic [63:0]                  rx_payload,
   input  wire logic                    rx_release,
   output logic                         rx_irq,
   output logic                         overrun_flag,
   input  wire logic                    overrun_clear
);
   localparam int FW = `CRX_FRAME_W + 3;

   typedef struct packed {
      crx_state_t                 st;
      logic [`CRX_FRAME_W-1:0]    bg;       // background_rx_buffer
      logic                       own;
      logic                       rx_irq;
      logic                       ovr;
   } crx_st_t;
   crx_st_t s_q, s_d;

   logic [7:0] match;
   logic [2:0] hit;
   logic       accept;
   logic       push, fifo_ready, out_valid;
   logic [FW-1:0] fifo_out;
   logic [FW-1:0] fifo_in;

   // per byte match, mask one means don't care
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_byte
         logic [7:0] idb;
         // id word packs as byte 0 = most significant
         assign idb = s_q.bg[`CRX_FRAME_W-1-8*(g%4) -: 8];
         assign match[g] = &((~(idb ^ acceptance_code_regs[8*g +: 8]))
                             | acceptance_mask_regs[8*g +: 8]);
      end
   endgenerate

   // mode decode, lowest filter wins
   always_comb begin
      hit    = `CRX_HIT_NONE;
      accept = 1'b0;
      case (acceptance_mode)
         `CRX_MODE_TWO: begin
            if (&match[3:0]) begin accept = 1'b1; hit = 3'h0; end
            else if (&match[7:4]) begin accept = 1'b1; hit = 3'h1; end
         end
         `CRX_MODE_FOUR: begin
            for (int f = 3; f >= 0; f--) begin
               if (&match[2*f +: 2]) begin accept = 1'b1; hit = 3'(f); end
            end
         end
         `CRX_MODE_EIGHT: begin
            for (int f = 7; f >= 0; f--) begin
               if (match[f]) begin accept = 1'b1; hit = 3'(f); end
            end
         end
         default: begin
            accept = 1'b0;
            hit    = `CRX_HIT_NONE;
         end
      endcase
   end

   // store only a good accepted frame that is not own outside loopback
   assign push = (s_q.st != CRX_IDLE) && frame_done && !frame_error && accept
                 && (!s_q.own || loopback_en);
   // own frame is never acknowledged unless looped back
   assign ack_enable = !s_q.own || loopback_en;
   assign fifo_in = {s_q.bg, hit};

   always_comb begin
      s_d = s_q;
      s_d.rx_irq = 1'b0;
      if (overrun_clear) s_d.ovr = 1'b0;
      case (s_q.st)
         CRX_IDLE: begin
            if (frame_start) begin
               s_d.st  = tx_active ? CRX_XMIT : CRX_RECV;
               s_d.own = tx_active;
            end
         end
         CRX_XMIT: begin
            if (arb_lost) begin
               s_d.st  = CRX_RECV;
               s_d.own = 1'b0;
            end
         end
         CRX_RECV: s_d.st = CRX_RECV;
         default: s_d.st = CRX_IDLE;
      endcase
      if (s_q.st != CRX_IDLE) s_d.bg = {frame_id_word, frame_payload};
      if (frame_done && s_q.st != CRX_IDLE) begin
         s_d.st  = CRX_IDLE;            // buffer free for next frame
         s_d.own = 1'b0;
         if (push && fifo_ready) s_d.rx_irq = 1'b1;
         if (push && !fifo_ready && overrun_irq_en) s_d.ovr = 1'b1; // set wins
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // fifo drops when full, transmit is untouched
   crx_fifo #(.W(FW), .D(`CRX_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (fifo_in),
      .out_valid (out_valid),
      .out_ready (rx_release),
      .out_data  (fifo_out)
   );

   // hit index travels with the frame
   assign rx_buffer_full_flag = out_valid;
   assign filter_hit_index    = fifo_out[2:0];
   assign rx_id_word          = fifo_out[FW-1 -: `CRX_IDW_W];
   assign rx_payload          = fifo_out[3 +: 64];
   assign rx_irq              = s_q.rx_irq;
   assign overrun_flag        = s_q.ovr;

   a_drop_full: assert property (@(posedge clk) disable iff (srst)
      ce && push && !fifo_ready && !rx_release |=> $stable(u_fifo.s_q.cnt))
      else $error("frame stored into full fifo");
   a_own_no_store: assert property (@(posedge clk) disable iff (srst)
      s_q.own && !loopback_en |-> !push)
      else $error("own frame stored outside loopback");
   a_own_no_ack: assert property (@(posedge clk) disable iff (srst)
      s_q.own && !loopback_en |-> !ack_enable)
      else $error("own frame acknowledged");
   a_error_drop: assert property (@(posedge clk) disable iff (srst)
      frame_error |-> !push)
      else $error("errored frame stored");
   a_arb_receiver: assert property (@(posedge clk) disable iff (srst)
      ce && s_q.st == CRX_XMIT && arb_lost && !frame_done |=> s_q.st == CRX_RECV)
      else $error("no receiver after lost arbitration");
   a_full_flag: assert property (@(posedge clk) disable iff (srst)
      ce && push && fifo_ready |=> rx_buffer_full_flag)
      else $error("full flag not set after accept");
   a_low_hit: assert property (@(posedge clk) disable iff (srst)
      acceptance_mode == `CRX_MODE_EIGHT && match[0] |-> hit == 3'h0)
      else $error("lower filter lost priority");
   a_irq_push: assert property (@(posedge clk) disable iff (srst)
      rx_irq |-> $past(push) && $past(fifo_ready))
      else $error("receive irq without store");
   a_resume: assert property (@(posedge clk) disable iff (srst)
      ce && !fifo_ready && rx_release |=> fifo_ready)
      else $error("fifo not reopened after release");
   c_loop_store: cover property (@(posedge clk) s_q.own && loopback_en && push);
   c_overrun: cover property (@(posedge clk) push && !fifo_ready);
   c_arb_lost: cover property (@(posedge clk) s_q.st == CRX_XMIT && arb_lost);
endmodule

// File: tb/crx_bus_model.sv
// behavioural can bus partner that hands frames to the receive path
`timescale 1ns/1ns
module crx_bus_model (
   input  wire logic clk,
   input  wire logic ack_enable,
   output logic      ack_low,
   output logic      tx_active,
   output logic      arb_lost,
   output logic      frame_start,
   output logic      frame_done,
   output logic      frame_error,
   output logic [31:0] frame_id_word,
   output logic [63:0] frame_payload
);
   initial begin
      {ack_low, tx_active, arb_lost, frame_start, frame_done, frame_error} = 6'h0;
      frame_id_word = 32'h0;
      frame_payload = 64'h0;
   end
   // one frame; own marks our transmission, lose drops arbitration midway
   task automatic send(input logic [31:0] id, input logic [63:0] pl,
                       input logic err, input logic own, input logic lose);
      @(posedge clk); #1;
      tx_active = own;
      frame_start = 1;
      ack_low = 0;
      frame_id_word = ~id;  // fields still shifting in
      frame_payload = ~pl;
      @(posedge clk); #1;
      frame_start = 0;
      frame_id_word = id;
      frame_payload = pl;
      arb_lost = lose;
      if (ack_enable !== 1'b1) ack_low = 1;
      @(posedge clk); #1;
      arb_lost = 0;
      if (lose) tx_active = 0;
      frame_done = 1;
      frame_error = err;
      @(posedge clk); #1;
      {frame_done, frame_error, tx_active} = 3'h0;
      frame_id_word = ~id;  // released bus shows no stale value
      frame_payload = ~pl;
   endtask
endmodule

// File: tb/test_can_rx_fifo_and_id_filter.sv
// self-checking bench for the can receive fifo and identifier filter
`timescale 1ns/1ns
`include "crx_map.svh"
module test_can_rx_fifo_and_id_filter;
   logic        clk, srst, ce, loopback_en, overrun_irq_en, rx_release, overrun_clear;
   logic [1:0]  acceptance_mode;
   logic [63:0] code, mask;
   wire         tx_active, arb_lost, frame_start, frame_done, frame_error, ack_low;
   wire         ack_enable, rx_buffer_full_flag, rx_irq, overrun_flag;
   wire  [31:0] frame_id_word, rx_id_word;
   wire  [63:0] frame_payload, rx_payload;
   wire  [2:0]  filter_hit_index;
   int          error_cnt = 0, checks = 0, cyc = 0;
   crx_rx_filter dut (.clk(clk), .srst(srst), .ce(ce), .loopback_en(loopback_en),
      .overrun_irq_en(overrun_irq_en), .acceptance_mode(acceptance_mode),
      .acceptance_code_regs(code), .acceptance_mask_regs(mask), .tx_active(tx_active),
      .arb_lost(arb_lost), .frame_start(frame_start), .frame_done(frame_done),
      .frame_error(frame_error), .frame_id_word(frame_id_word),
      .frame_payload(frame_payload), .ack_enable(ack_enable),
      .rx_buffer_full_flag(rx_buffer_full_flag), .filter_hit_index(filter_hit_index),
      .rx_id_word(rx_id_word), .rx_payload(rx_payload), .rx_release(rx_release),
      .rx_irq(rx_irq), .overrun_flag(overrun_flag), .overrun_clear(overrun_clear));
   crx_bus_model bus (.clk(clk), .ack_enable(ack_enable), .ack_low(ack_low),
      .tx_active(tx_active), .arb_lost(arb_lost), .frame_start(frame_start),
      .frame_done(frame_done), .frame_error(frame_error),
      .frame_id_word(frame_id_word), .frame_payload(frame_payload));
   // id byte 0 (bits 31:24) meets register 0, so banks hold ids byte-reversed
   function automatic logic [31:0] swap(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // compare the fifo head, then pop it with a one-cycle release
   task automatic pop_chk(input logic [31:0] id, input logic [63:0] pl, input logic [2:0] hit);
      chk(rx_buffer_full_flag, 1);
      chk(filter_hit_index, hit);
      chk(rx_id_word, id);
      chk(rx_payload, pl);
      rx_release = 1;
      @(posedge clk); #1;
      rx_release = 0;
   endtask
   // both banks match 123456aa, only bank 1 matches 773456aa, none 12345500
   task automatic t_hits;
      bus.send(32'h123456aa, 64'h11, 0, 0, 0);
      chk(rx_irq, 1);
      bus.send(32'h773456aa, 64'h22, 0, 0, 0);
      bus.send(32'h12345500, 64'h33, 0, 0, 0);
      bus.send(32'h123456aa, 64'h44, 1, 0, 0);
      pop_chk(32'h123456aa, 64'h11, 3'h0);
      pop_chk(32'h773456aa, 64'h22, 3'h1);
      chk(rx_buffer_full_flag, 0);
   endtask
   task automatic t_own;
      bus.send(32'h123456aa, 64'h55, 0, 1, 0);
      chk({ack_low, rx_buffer_full_flag, rx_irq}, 3'h4);
      loopback_en = 1;
      bus.send(32'h123456aa, 64'h66, 0, 1, 0);
      pop_chk(32'h123456aa, 64'h66, 3'h0);
      loopback_en = 0;
      bus.send(32'h773456aa, 64'h77, 0, 1, 1);
      pop_chk(32'h773456aa, 64'h77, 3'h1);
   endtask
   // a full fifo drops the fifth frame, one pop reopens it
   task automatic t_overrun;
      for (int i = 1; i <= 5; i++) bus.send(32'h123456aa, 64'(i), 0, 0, 0);
      chk(overrun_flag, 1);
      pop_chk(32'h123456aa, 64'h1, 3'h0);
      bus.send(32'h123456aa, 64'h6, 0, 0, 0);
      for (int i = 2; i <= 4; i++) pop_chk(32'h123456aa, 64'(i), 3'h0);
      pop_chk(32'h123456aa, 64'h6, 3'h0);
      overrun_clear = 1;
      @(posedge clk); #1;
      overrun_clear = 0;
      chk(overrun_flag, 0);
   endtask
   // four and eight filter modes, lowest matching filter wins
   task automatic t_modes;
      acceptance_mode = `CRX_MODE_FOUR;
      bus.send(32'h123456aa, 64'h91, 0, 0, 0);
      bus.send(32'h773456aa, 64'h92, 0, 0, 0);
      bus.send(32'h77349900, 64'h93, 0, 0, 0);
      pop_chk(32'h123456aa, 64'h91, 3'h0);
      pop_chk(32'h773456aa, 64'h92, 3'h1);
      pop_chk(32'h77349900, 64'h93, 3'h2);
      acceptance_mode = `CRX_MODE_EIGHT;
      bus.send(32'h773456aa, 64'h94, 0, 0, 0);
      bus.send(32'h779956bb, 64'h95, 0, 0, 0);
      pop_chk(32'h773456aa, 64'h94, 3'h1);
      pop_chk(32'h779956bb, 64'h95, 3'h2);
      chk(rx_buffer_full_flag, 0);
   endtask
   task automatic t_closed;
      acceptance_mode = `CRX_MODE_CLOSED;
      bus.send(32'h123456aa, 64'h88, 0, 0, 0);
      chk(rx_buffer_full_flag, 0);
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // hang guard, far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   initial begin
      {srst, ce, loopback_en, overrun_irq_en, rx_release, overrun_clear} = 6'h34;
      acceptance_mode = `CRX_MODE_TWO;  // extended ids only here
      code = {swap(32'h003456aa), swap(32'h12345600)};
      mask = {swap(32'hff000000), swap(32'h000000ff)};
      repeat (6) @(posedge clk);
      #1 srst = 0;
      t_hits;
      t_own;
      t_overrun;
      t_modes;
      t_closed;
      report_and_stop;
   end
endmodule
